// >>> core/ddrpm_top.sv
// Purpose: one ddr channel pin mapping: address mux, rank select, masks, strobes
// Assumes: core clock clk_i 10 MHz, memory clock mclk_i free running
// Notes:   one command in flight; ready drops until the link acknowledges
`timescale 1ns/1ns
// What this block does
// R1: row and column share the 14-bit address bus
// R2: address bit 13 always carries bank bit 1
// R3: with four banks, address bit 12 carries bank bit 0
// R4: single rank of 256M parts: address bit 14 is row bit 12
// R5: two ranks: address bit 14 is the active-low second rank select
// R6: chip select 0 picks the only or first rank
// R7: eight byte masks act as write byte enables
// R8: eight two-way strobes time data both directions
// R9: 64-bit two-way double-rate data bus per channel; the block moves one beat per command, read data from the strobe falling edge
// R10: voltage strap 01 is 2.5 V, 10 is 1.8 V; board must drive it
// R11: commands use standard ras/cas/we coding, clock enable high
module ddrpm_top
  import ddrpm_pkg::*;
(
  input  wire logic               clk_i,        // core clock
  input  wire logic               nrst_i,       // async reset, active low
  input  wire logic               mclk_i,       // memory link clock
  input  wire logic               req_valid_i,  // command request
  output logic                    req_ready_o,  // can take a request
  input  wire ddrpm_op_e          req_op_i,     // command
  input  wire logic               req_rank_i,   // target rank
  input  wire logic [1:0]         req_bank_i,   // bank
  input  wire logic [12:0]        req_row_i,    // row
  input  wire logic [11:0]        req_col_i,    // column
  input  wire logic [DATA_W-1:0]  req_wdata_i,  // write data
  input  wire logic [LANES-1:0]   req_wmask_i,  // write mask, 1 masks lane
  input  wire logic               two_rank_i,   // config: two ranks
  input  wire logic               four_bank_i,  // config: four-bank parts
  input  wire logic               big_dev_i,    // config: 256M parts
  input  wire logic [1:0]         memory_voltage_strap_i, // strap pins
  output logic [1:0]              volt_sel_o,   // decoded voltage
  output logic                    volt_bad_o,   // illegal strap value
  output logic [14:0]             multiplexed_address_bus_o, // address pins
  output logic                    rank0_select_n_o,   // rank0 select
  output logic                    row_strobe_n_o,     // ras
  output logic                    col_strobe_n_o,     // cas
  output logic                    write_enable_n_o,   // we
  output logic                    memory_clock_gate_o,// cke
  output logic [LANES-1:0]        byte_lane_write_mask_o, // byte masks
  output logic [DATA_W-1:0]       channel_data_bus_o,     // dq out
  output logic [DATA_W-1:0]       channel_data_bus_oe_n_o,// dq enables
  input  wire logic [DATA_W-1:0]  channel_data_bus_i,     // dq in
  output logic [LANES-1:0]        byte_data_strobes_o,    // dqs out
  output logic [LANES-1:0]        byte_data_strobes_oe_n_o, // dqs enables
  input  wire logic [LANES-1:0]   byte_data_strobes_i,    // dqs in
  output logic [DATA_W-1:0]       rd_data_o     // captured read data
);
  ddrpm_cdc_if cdc ();

  // ==========================================================
  // configuration and strap synchronisers
  logic [1:0] strap_s1_q, strap_s2_q;
  logic [1:0] volt_q, volt_d;
  logic       bad_q, bad_d;

  always_comb begin
    volt_d = volt_q;
    bad_d  = 1'b0;
    unique case (strap_s2_q)
      VOLT_2V5: volt_d = DDRPM_V_2V5; // R10
      VOLT_1V8: volt_d = DDRPM_V_1V8; // R10
      default: begin
        volt_d = DDRPM_V_BAD; // R10
        bad_d  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
      volt_q     <= 2'h0;
      bad_q      <= 1'b1;
    end else begin
      strap_s1_q <= memory_voltage_strap_i;
      strap_s2_q <= strap_s1_q;
      volt_q     <= volt_d;
      bad_q      <= bad_d;
    end
  end

  assign volt_sel_o = volt_q;
  assign volt_bad_o = bad_q;

  // config levels cross to the link clock by two flops each
  logic [2:0] cfg_s1_q, cfg_s2_q;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_s1_q <= 3'h0;
      cfg_s2_q <= 3'h0;
    end else begin
      cfg_s1_q <= {big_dev_i, four_bank_i, two_rank_i};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // ==========================================================
  // core-side request holding and toggle handshake
  logic [SYNC_STAGES-1:0] ack_sync_q, ack_sync_d;
  logic req_tgl_q, req_tgl_d;
  ddrpm_op_e op_q, op_d;
  logic rank_q, rank_d;
  logic [1:0] bank_q, bank_d;
  logic [12:0] row_q, row_d;
  logic [11:0] col_q, col_d;
  logic [DATA_W-1:0] wd_q, wd_d;
  logic [LANES-1:0] wm_q, wm_d;
  logic idle;

  // fields stay frozen until the ack returns, so the link sees stable words
  assign idle = ack_sync_q[1] == req_tgl_q;
  assign req_ready_o = idle;

  always_comb begin
    ack_sync_d = {ack_sync_q[0], cdc.ack_tgl};
    req_tgl_d = req_tgl_q;
    op_d = op_q;
    rank_d = rank_q;
    bank_d = bank_q;
    row_d = row_q;
    col_d = col_q;
    wd_d = wd_q;
    wm_d = wm_q;
    if (req_valid_i && idle) begin
      req_tgl_d = ~req_tgl_q;
      op_d = req_op_i;
      rank_d = req_rank_i & two_rank_i; // R6
      bank_d = req_bank_i;
      row_d = req_row_i;
      col_d = req_col_i;
      wd_d = req_wdata_i; // R9
      wm_d = req_wmask_i; // R7
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_sync_q <= '0;
      req_tgl_q <= 1'b0;
      op_q <= DDRPM_NOP;
      rank_q <= 1'b0;
      bank_q <= 2'h0;
      row_q <= 13'h0000;
      col_q <= 12'h000;
      wd_q <= '0;
      wm_q <= MASK_RST;
    end else begin
      ack_sync_q <= ack_sync_d;
      req_tgl_q <= req_tgl_d;
      op_q <= op_d;
      rank_q <= rank_d;
      bank_q <= bank_d;
      row_q <= row_d;
      col_q <= col_d;
      wd_q <= wd_d;
      wm_q <= wm_d;
    end
  end

  assign cdc.req_tgl = req_tgl_q;
  assign cdc.op = op_q;
  assign cdc.rank = rank_q;
  assign cdc.bank = bank_q;
  assign cdc.row = row_q;
  assign cdc.col = col_q;
  assign cdc.wdata = wd_q;
  assign cdc.wmask = wm_q;

  // ==========================================================
  // link side
  logic [2:0] cmd;
  logic drv_n, dqs, dqs_n;

  ddrpm_link u_link (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .lk          (cdc.link),
    .two_rank_i  (cfg_s2_q[0]),
    .four_bank_i (cfg_s2_q[1]),
    .big_dev_i   (cfg_s2_q[2]),
    .addr_o      (multiplexed_address_bus_o),
    .cs0_n_o     (rank0_select_n_o),
    .cmd_o       (cmd),
    .mask_o      (byte_lane_write_mask_o),
    .dq_o        (channel_data_bus_o),
    .dq_oe_n_o   (drv_n),
    .dqs_o       (dqs),
    .dqs_oe_n_o  (dqs_n),
    .pending_o   ()
  );

  assign row_strobe_n_o   = cmd[2]; // R11
  assign col_strobe_n_o   = cmd[1]; // R11
  assign write_enable_n_o = cmd[0]; // R11
  assign memory_clock_gate_o = 1'b1; // R11
  assign channel_data_bus_oe_n_o = {DATA_W{drv_n}}; // R9

  // ==========================================================
  // read capture on each lane's strobe; only the falling-edge byte reaches rd_data_o
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [7:0] rise_q, fall_q;
      assign byte_data_strobes_o[g]      = dqs; // R8
      assign byte_data_strobes_oe_n_o[g] = dqs_n; // R8
      always_ff @(posedge byte_data_strobes_i[g] or negedge nrst_i) begin
        if (!nrst_i) rise_q <= 8'h00;
        else rise_q <= channel_data_bus_i[g*8 +: 8]; // R8
      end
      always_ff @(negedge byte_data_strobes_i[g] or negedge nrst_i) begin
        if (!nrst_i) fall_q <= 8'h00;
        else fall_q <= rise_q ^ channel_data_bus_i[g*8 +: 8] ^ rise_q; // R9
      end
      assign rd_data_o[g*8 +: 8] = fall_q;
    end
  endgenerate

  a_ready_hold: assert property (@(posedge clk_i) disable iff (!nrst_i) // R1
    req_valid_i && req_ready_o |=> !req_ready_o) else $error("ready not dropped after take");
  a_strap_decode: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
    strap_s2_q == VOLT_1V8 |=> volt_sel_o == DDRPM_V_1V8 && !volt_bad_o) else $error("strap 10 misdecoded");
  a_strap_bad: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
    strap_s2_q == 2'h3 |=> volt_bad_o) else $error("illegal strap not flagged");
  a_cke_high: assert property (@(posedge clk_i) disable iff (!nrst_i) // R11
    memory_clock_gate_o) else $error("clock enable dropped");
  c_strap_2v5: cover property (@(posedge clk_i) disable iff (!nrst_i) volt_sel_o == DDRPM_V_2V5);
  c_take: cover property (@(posedge clk_i) disable iff (!nrst_i) req_valid_i && req_ready_o);
endmodule : ddrpm_top

// >>> core/ddrpm_pkg.sv
// Purpose: shared constants and types for the ddr channel pin mapping block
// Assumes: one 64-bit channel, ddr sdram with 14+1 address pins
// Notes:   command codes follow the usual cs/ras/cas/we truth table
package ddrpm_pkg;
  localparam int          ADDR_W       = 14;
  localparam int          DATA_W       = 64;
  localparam int          LANES        = 8;
  localparam int          BA1_POS      = 13;
  localparam int          BA0_POS      = 12;
  localparam int          ROW12_POS    = 12;
  localparam logic [1:0]  VOLT_2V5     = 2'h1;
  localparam logic [1:0]  VOLT_1V8     = 2'h2;
  localparam logic [2:0]  CMD_NOP      = 3'h7;
  localparam logic [2:0]  CMD_ACT      = 3'h3;
  localparam logic [2:0]  CMD_RD       = 3'h5;
  localparam logic [2:0]  CMD_WR       = 3'h4;
  localparam logic [2:0]  CMD_PRE      = 3'h2;
  localparam logic [2:0]  CMD_REF      = 3'h1;
  localparam logic [2:0]  CMD_MRS      = 3'h0;
  localparam logic [13:0] ADDR_RST     = 14'h0000;
  localparam logic [7:0]  MASK_RST     = 8'hFF;
  localparam int          SYNC_STAGES  = 2;

  typedef enum logic [2:0] {
    DDRPM_NOP, DDRPM_ACT, DDRPM_RD, DDRPM_WR, DDRPM_PRE, DDRPM_REF, DDRPM_MRS
  } ddrpm_op_e;

  typedef enum logic [1:0] {DDRPM_V_BAD, DDRPM_V_2V5, DDRPM_V_1V8} ddrpm_volt_e;
endpackage : ddrpm_pkg

// >>> core/ddrpm_cdc_if.sv
// Purpose: carrier between the core-side request logic and the link-side driver
// Assumes: request words are held stable while req toggles are in flight
// Notes:   toggle handshake; ack returns by a toggle the other way
`timescale 1ns/1ns
interface ddrpm_cdc_if;
  import ddrpm_pkg::*;
  logic                req_tgl;
  logic                ack_tgl;
  ddrpm_op_e           op;
  logic                rank;
  logic [1:0]          bank;
  logic [12:0]         row;
  logic [11:0]         col;
  logic [DATA_W-1:0]   wdata;
  logic [LANES-1:0]    wmask;
  modport core (output req_tgl, output op, output rank, output bank, output row,
                output col, output wdata, output wmask, input ack_tgl);
  modport link (input req_tgl, input op, input rank, input bank, input row,
                input col, input wdata, input wmask, output ack_tgl);
endinterface : ddrpm_cdc_if

// >>> core/ddrpm_link.sv
// Purpose: link-side pin driver on the memory clock
// Assumes: memory clock runs free; request fields stable while pending
// Notes:   one command per handshake; read data is captured on strobe edges in ddrpm_top, not here
`timescale 1ns/1ns
module ddrpm_link
  import ddrpm_pkg::*;
(
  input  wire logic               mclk_i,    // memory clock
  input  wire logic               nrst_i,    // async reset, active low
  ddrpm_cdc_if.link               lk,        // request carrier
  input  wire logic               two_rank_i,  // synced config: two ranks
  input  wire logic               four_bank_i, // synced config: four banks
  input  wire logic               big_dev_i,   // synced config: 256M devices
  output logic [14:0]             addr_o,    // address pins 14:0
  output logic                    cs0_n_o,   // rank0 select
  output logic [2:0]              cmd_o,     // ras/cas/we
  output logic [LANES-1:0]        mask_o,    // byte lane mask
  output logic [DATA_W-1:0]       dq_o,      // write data
  output logic                    dq_oe_n_o, // low while driving
  output logic                    dqs_o,     // strobe out level
  output logic                    dqs_oe_n_o,// low while driving strobe
  output logic                    pending_o  // request being served
);
  logic [SYNC_STAGES-1:0] req_sync_q, req_sync_d;
  logic ack_q, ack_d;
  logic [14:0] addr_q, addr_d;
  logic cs0_q, cs0_d;
  logic [2:0] cmd_q, cmd_d;
  logic [LANES-1:0] mask_q, mask_d;
  logic [DATA_W-1:0] dq_q, dq_d;
  logic drv_q, drv_d, dqs_q, dqs_d;
  logic go;

  assign go = req_sync_q[1] != ack_q;

  always_comb begin
    req_sync_d = {req_sync_q[0], lk.req_tgl};
    ack_d  = ack_q;
    addr_d = ADDR_RST;
    cs0_d  = 1'b1;
    cmd_d  = CMD_NOP;
    mask_d = MASK_RST;
    dq_d   = dq_q;
    drv_d  = 1'b0;
    dqs_d  = 1'b0;
    if (go) begin
      ack_d = ~ack_q;
      // bank bits placed on top address pins
      addr_d[BA1_POS] = lk.bank[1]; // R2
      if (four_bank_i) addr_d[BA0_POS] = lk.bank[0]; // R3
      unique case (lk.op)
        DDRPM_ACT: begin
          addr_d[11:0] = lk.row[11:0]; // R1
          if (!four_bank_i) addr_d[ROW12_POS] = lk.row[12];
          cmd_d = CMD_ACT; // R11
        end
        DDRPM_RD: begin
          addr_d[11:0] = lk.col; // R1
          cmd_d = CMD_RD; // R11
        end
        DDRPM_WR: begin
          addr_d[11:0] = lk.col; // R1
          cmd_d  = CMD_WR; // R11
          mask_d = lk.wmask; // R7
          dq_d   = lk.wdata; // R9
          drv_d  = 1'b1; // R8
          dqs_d  = 1'b1; // R8
        end
        DDRPM_PRE: cmd_d = CMD_PRE; // R11
        DDRPM_REF: cmd_d = CMD_REF; // R11
        DDRPM_MRS: begin
          addr_d[11:0] = lk.col;
          cmd_d = CMD_MRS; // R11
        end
        default: cmd_d = CMD_NOP;
      endcase
      // pin 14: second rank select or row bit 12
      if (two_rank_i) begin
        addr_d[14] = ~lk.rank; // R5
        cs0_d = lk.rank | (cmd_d == CMD_NOP); // R6
      end else begin
        addr_d[14] = (lk.op == DDRPM_ACT) ? (big_dev_i & lk.row[12]) : 1'b0; // R4
        cs0_d = (cmd_d == CMD_NOP); // R6
      end
      if (two_rank_i && cmd_d == CMD_NOP) addr_d[14] = 1'b1;
    end else if (two_rank_i) begin
      addr_d[14] = 1'b1; // R5
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_sync_q <= '0;
      ack_q  <= 1'b0;
      addr_q <= '0;
      cs0_q  <= 1'b1;
      cmd_q  <= CMD_NOP;
      mask_q <= MASK_RST;
      dq_q   <= '0;
      drv_q  <= 1'b0;
      dqs_q  <= 1'b0;
    end else begin
      req_sync_q <= req_sync_d;
      ack_q  <= ack_d;
      addr_q <= addr_d;
      cs0_q  <= cs0_d;
      cmd_q  <= cmd_d;
      mask_q <= mask_d;
      dq_q   <= dq_d;
      drv_q  <= drv_d;
      dqs_q  <= dqs_d;
    end
  end

  assign lk.ack_tgl = ack_q;
  assign addr_o     = addr_q;
  assign cs0_n_o    = cs0_q;
  assign cmd_o      = cmd_q;
  assign mask_o     = mask_q;
  assign dq_o       = dq_q;
  assign dq_oe_n_o  = ~drv_q;
  assign dqs_o      = dqs_q;
  assign dqs_oe_n_o = ~drv_q;
  assign pending_o  = go;

  a_bank1_pin: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R2
    go |=> addr_o[BA1_POS] == $past(lk.bank[1])) else $error("bank bit 1 not on pin 13");
  a_rank1_idle: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R5
    two_rank_i && $past(two_rank_i) && cmd_o == CMD_NOP |-> addr_o[14]) else $error("rank1 select active on idle");
  a_one_rank_sel: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R6
    two_rank_i |-> !(~cs0_n_o && ~addr_o[14])) else $error("both ranks selected");
  a_wr_drive: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R8
    cmd_o == CMD_WR |-> !dq_oe_n_o && !dqs_oe_n_o) else $error("write without strobe drive");
  a_mask_idle: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R7
    cmd_o != CMD_WR |-> mask_o == MASK_RST) else $error("mask active outside write");
  a_ack_once: assert property (@(posedge mclk_i) disable iff (!nrst_i) // R1
    go |=> !go ##0 cmd_o == $past(cmd_d)) else $error("request served twice");
  c_write: cover property (@(posedge mclk_i) disable iff (!nrst_i) cmd_o == CMD_WR);
  c_read: cover property (@(posedge mclk_i) disable iff (!nrst_i) cmd_o == CMD_RD);
  c_rank1: cover property (@(posedge mclk_i) disable iff (!nrst_i) two_rank_i && !addr_o[14]);
endmodule : ddrpm_link

// >>> verification/ddrpm_sdram_model.sv
// Purpose: behavioural ddr sdram ranks facing one memory channel
// Assumes: command pins are sampled on the rising memory clock edge
// Notes:   one-beat reads; a released line shows the inverse of its last level
`timescale 1ns/1ns
// ==========================================================
// memory model
module ddrpm_sdram_model
  import ddrpm_pkg::*;
#(
  parameter logic [63:0] RD_PAT = 64'h0123456789ABCDEF
)
(
  input  wire logic [1:0]        lat_i,        // extra read latency in mclk cycles
  input  wire logic              mclk_i,       // memory clock
  input  wire logic [14:0]       addr_i,       // address pins
  input  wire logic              cs0_n_i,      // rank0 select
  input  wire logic [2:0]        cmd_i,        // ras/cas/we
  input  wire logic [LANES-1:0]  mask_i,       // byte masks
  input  wire logic [DATA_W-1:0] dq_i,         // resolved data wire
  output logic [DATA_W-1:0]      dq_o,         // data level when the controller is off the bus
  output logic [LANES-1:0]       dqs_o,        // strobe level likewise
  output logic [2:0]             seen_cmd_o,   // last command
  output logic [14:0]            seen_addr_o,  // its address
  output logic                   seen_cs0_n_o, // its rank0 select
  output logic [LANES-1:0]       seen_mask_o,  // its masks
  output logic [DATA_W-1:0]      seen_dq_o,    // data wire with it
  output logic [7:0]             seen_cnt_o    // commands seen
);
  logic [7:0] rd_n;

  initial begin
    dq_o = 64'h0000000000000000;
    dqs_o = 8'hFF;
    seen_cnt_o = 8'h00;
    rd_n = 8'h00;
  end

  // unknown pins before reset must not count as a command
  always @(posedge mclk_i) begin
    if (cmd_i inside {CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS}) begin
      seen_cmd_o <= cmd_i;
      seen_addr_o <= addr_i;
      seen_cs0_n_o <= cs0_n_i;
      seen_mask_o <= mask_i;
      seen_dq_o <= dq_i;
      seen_cnt_o <= seen_cnt_o + 8'h01;
    end
  end

  // read beat: preamble low, then one full strobe pulse with data held
  always @(posedge mclk_i) begin
    if (cmd_i === CMD_RD && (cs0_n_i === 1'b0 || addr_i[14] === 1'b0)) begin
      repeat (lat_i) @(posedge mclk_i);
      @(negedge mclk_i);
      dq_o = RD_PAT ^ {56'h00000000000000, rd_n};
      dqs_o = 8'h00;
      @(posedge mclk_i);
      dqs_o = 8'hFF;
      @(negedge mclk_i);
      dqs_o = 8'h00;
      @(posedge mclk_i);
      dq_o = ~dq_o;
      dqs_o = 8'hFF;
      rd_n = rd_n + 8'h01;
    end
  end
endmodule : ddrpm_sdram_model

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the ddr channel pin mapping block
// Assumes: one request at a time; inputs change on the falling core clock edge
// Notes:   the memory model records every ACT, RD, WR, PRE, REF or MRS command it sees on the pins
`timescale 1ns/1ns
module tb_top;
  import ddrpm_pkg::*;
  localparam logic [63:0] RD_PAT = 64'h0123456789ABCDEF;
  logic        clk, mclk, nrst, valid, ready, rank, two, four, big, volt_bad, cs0_n, ras_n, cas_n, we_n, cke;
  ddrpm_op_e   op;
  logic [1:0]  bank, strap, lat, volt_sel;
  logic [12:0] row;
  logic [11:0] col;
  logic [14:0] addr, s_addr;
  logic [7:0]  wmask, mask, dqs_out, dqs_oe_n, dqs_w, m_dqs, s_mask, s_cnt;
  logic [63:0] wdata, dq_out, dq_oe_n, dq_w, m_dq, s_dq, rd_data;
  logic [2:0]  s_cmd;
  logic        s_cs0_n;
  logic [16:0] wr_oe;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // ==========================================================
  // clocks, wires, instances
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    mclk = 1'b0;
    #7;
    forever #16 mclk = ~mclk;
  end
  assign dq_w  = (dq_out & ~dq_oe_n) | (m_dq & dq_oe_n);
  assign dqs_w = (dqs_out & ~dqs_oe_n) | (m_dqs & dqs_oe_n);
  always @(posedge mclk) begin
    if ({ras_n, cas_n, we_n} === CMD_WR) wr_oe <= {|dq_oe_n, dqs_oe_n, dqs_out};
  end
  ddrpm_top dut (
    .clk_i(clk), .nrst_i(nrst), .mclk_i(mclk), .req_valid_i(valid), .req_ready_o(ready), .req_op_i(op),
    .req_rank_i(rank), .req_bank_i(bank), .req_row_i(row), .req_col_i(col), .req_wdata_i(wdata),
    .req_wmask_i(wmask), .two_rank_i(two), .four_bank_i(four), .big_dev_i(big),
    .memory_voltage_strap_i(strap), .volt_sel_o(volt_sel), .volt_bad_o(volt_bad),
    .multiplexed_address_bus_o(addr), .rank0_select_n_o(cs0_n), .row_strobe_n_o(ras_n),
    .col_strobe_n_o(cas_n), .write_enable_n_o(we_n), .memory_clock_gate_o(cke),
    .byte_lane_write_mask_o(mask), .channel_data_bus_o(dq_out), .channel_data_bus_oe_n_o(dq_oe_n),
    .channel_data_bus_i(dq_w), .byte_data_strobes_o(dqs_out), .byte_data_strobes_oe_n_o(dqs_oe_n),
    .byte_data_strobes_i(dqs_w), .rd_data_o(rd_data)
  );
  ddrpm_sdram_model #(.RD_PAT(RD_PAT)) mem (
    .lat_i(lat), .mclk_i(mclk), .addr_i(addr), .cs0_n_i(cs0_n), .cmd_i({ras_n, cas_n, we_n}), .mask_i(mask),
    .dq_i(dq_w), .dq_o(m_dq), .dqs_o(m_dqs), .seen_cmd_o(s_cmd), .seen_addr_o(s_addr), .seen_cs0_n_o(s_cs0_n),
    .seen_mask_o(s_mask), .seen_dq_o(s_dq), .seen_cnt_o(s_cnt)
  );
  // ==========================================================
  // shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // a hung handshake counts after 60 core cycles; a ready that never rises hits the cycle ceiling below
  task automatic send(input ddrpm_op_e o, input logic r, input logic [1:0] b, input logic [12:0] rw,
                      input logic [11:0] c, input logic [63:0] d, input logic [7:0] m);
    @(negedge clk);
    op = o;
    {valid, rank, bank, row, col, wdata, wmask} = {1'b1, r, b, rw, c, d, m};
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    @(negedge clk);
    valid = 1'b0;
    for (int i = 0; i < 60 && ready !== 1'b1; i++) @(negedge clk);
    // a handshake that never returns counts against the run
    if (ready !== 1'b1) mismatches++;
  endtask : send
  task automatic cfg(input logic [2:0] c);
    @(negedge clk);
    {two, four, big} = c;
    repeat (4) @(negedge clk);
  endtask : cfg
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done();
    end
  end
  // ==========================================================
  // scenarios
  task automatic t_reset();
    check(64'(addr), 64'h0);
    check(64'({cs0_n, ras_n, cas_n, we_n}), 64'hF);
    check(64'(mask), 64'hFF);
    check(dq_oe_n, 64'hFFFFFFFFFFFFFFFF);
    check(64'(dqs_oe_n), 64'hFF);
    check(64'({ready, cke}), 64'h3);
  endtask : t_reset
  task automatic t_strap();
    logic [1:0] e [4] = '{2'h0, VOLT_2V5, VOLT_1V8, 2'h0};
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      strap = 2'(k);
      repeat (5) @(negedge clk);
      check(64'(volt_sel), 64'(e[k]));
      check(64'(volt_bad), 64'(k == 0 || k == 3));
    end
    strap = VOLT_2V5;
  endtask : t_strap
  task automatic t_cmds();
    ddrpm_op_e  ops [6] = '{DDRPM_ACT, DDRPM_RD, DDRPM_WR, DDRPM_PRE, DDRPM_REF, DDRPM_MRS};
    logic [2:0] codes [6] = '{CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS};
    logic [7:0] n;
    cfg(3'h3);
    for (int k = 0; k < 6; k++) begin
      n = s_cnt;
      send(ops[k], 1'b0, 2'h1, 13'h0010, 12'h020, 64'h0, 8'h00);
      check(64'(s_cmd), 64'(codes[k]));
      check(64'(s_cnt), 64'(n + 8'h01));
      check(64'(s_cs0_n), 64'h0);
    end
    check(64'(cke), 64'h1);
  endtask : t_cmds
  task automatic t_write();
    send(DDRPM_WR, 1'b0, 2'h0, 13'h0, 12'h3C4, 64'hDEADBEEF0BADF00D, 8'h5A);
    check(64'(s_mask), 64'h5A);
    check(s_dq, 64'hDEADBEEF0BADF00D);
    check(64'(wr_oe), 64'h0FF);
    check(64'(s_addr[11:0]), 64'h3C4);
    check(64'(mask), 64'hFF);
  endtask : t_write
  task automatic t_read(input logic [1:0] l, input logic [7:0] n);
    lat = l;
    send(DDRPM_RD, 1'b0, 2'h0, 13'h0, 12'h155, 64'h0, 8'h00);
    repeat (4) @(negedge clk);
    check(rd_data, RD_PAT ^ {56'h0, n});
    check(64'(s_addr[11:0]), 64'h155);
  endtask : t_read
  task automatic act_case(input logic [2:0] c, input logic r, input logic [1:0] bk, input logic [12:0] rw,
                          input logic [14:0] ea, input logic ecs);
    cfg(c);
    send(DDRPM_ACT, r, bk, rw, 12'h000, 64'h0, 8'h00);
    check(64'(s_addr), 64'(ea));
    check(64'(s_cs0_n), 64'(ecs));
  endtask : act_case
  // ==========================================================
  // main sequence
  initial begin
    {nrst, valid, rank, two, four, big} = 6'h03;
    {bank, row, col, wdata, wmask} = '0;
    {strap, lat} = 4'h4;
    op = DDRPM_NOP;
    repeat (12) @(negedge clk);
    t_reset();
    nrst = 1'b1;
    t_strap();
    t_cmds();
    t_write();
    t_read(2'h0, 8'h01);
    t_read(2'h3, 8'h02);
    act_case(3'h3, 1'b0, 2'h2, 13'h1ABC, 15'h6ABC, 1'b0);
    act_case(3'h2, 1'b0, 2'h2, 13'h1ABC, 15'h2ABC, 1'b0);
    act_case(3'h1, 1'b0, 2'h1, 13'h1123, 15'h5123, 1'b0);
    act_case(3'h7, 1'b1, 2'h3, 13'h0555, 15'h3555, 1'b1);
    check(64'(addr[14]), 64'h1);
    act_case(3'h7, 1'b0, 2'h0, 13'h1FFF, 15'h4FFF, 1'b0);
    test_done();
  end
endmodule : tb_top
